// >>> logic/startup_status_flags.sv
// Purpose: Startup status flags with APB access and axis enable gating
// Assumes: Config inputs and axis requests come from ref_clk_i logic
// Notes:   Flags change only when an evaluation completes or a reset command clears them
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none

module startup_status_flags #(
  parameter int EVAL_WINDOW = startup_status_pkg::EVAL_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [startup_status_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [startup_status_pkg::DATA_W-1:0] pwdata_i,
  output logic [startup_status_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Timing clock pins
  input wire logic phase_clk_i,
  input wire logic servo_clk_i,
  // Configuration store
  input wire logic factory_config_i,
  input wire logic config_modified_i,
  input wire logic config_saved_i,
  // Axis control
  input wire logic axis_enable_req_i,
  input wire logic axis_disable_req_i,
  output logic axis_enable_o,
  // Flags and interrupt
  output logic clock_missing_o,
  output logic factory_settings_o,
  output logic irq_o
);
  import startup_status_pkg::*;

  state_type state_reg;
  logic clock_missing_flag;
  logic factory_settings_flag;
  logic modified_reg;
  logic reinit_reg;
  logic reinit_watch;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_status_next;
  logic det_done;
  logic det_missing;
  logic det_run;
  logic evaluating;
  logic access;
  logic wr_done;
  logic addr_ok;
  logic reset_cmd;
  logic reinit_cmd;
  logic irq_clear_wr;
  logic axis_refused;
  logic factory_next;
  logic [DATA_W-1:0] read_value;

  // ----------------------------------------
  // Clock presence window
  // ----------------------------------------
  clock_presence_detector #(
    .WINDOW(EVAL_WINDOW),
    .CNT_W($clog2(EVAL_WINDOW + 1))
  ) detector (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(det_run),
    .phase_clk_i(phase_clk_i),
    .servo_clk_i(servo_clk_i),
    .done_o(det_done),
    .missing_o(det_missing)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // One wait state: read data comes from a register
  assign access = psel_i && penable_i && !pready_o;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign addr_ok = (paddr_i == STATUS_ADDR) || (paddr_i == COMMAND_ADDR) ||
                   (paddr_i == IRQ_STATUS_ADDR) || (paddr_i == IRQ_CLEAR_ADDR) ||
                   (paddr_i == IRQ_ENABLE_ADDR);
  assign reset_cmd = wr_done && (paddr_i == COMMAND_ADDR) && pwdata_i[CMD_RESET_BIT];
  assign reinit_cmd = wr_done && (paddr_i == COMMAND_ADDR) && pwdata_i[CMD_REINIT_BIT];
  assign irq_clear_wr = wr_done && (paddr_i == IRQ_CLEAR_ADDR);

  // ----------------------------------------
  // Evaluation sequencer
  // ----------------------------------------
  assign det_run = (state_reg == ST_EVAL);
  assign evaluating = (state_reg != ST_RUN);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_RESTART;
    end else if (reset_cmd) begin
      state_reg <= ST_RESTART;
    end else begin
      unique case (state_reg)
        ST_RESTART: begin
          state_reg <= ST_EVAL;
        end
        ST_EVAL: begin
          if (det_done) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RESTART;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Configuration tracking
  // ----------------------------------------
  // Set wins over a save in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      modified_reg <= 1'b0;
    end else if (config_modified_i) begin
      modified_reg <= 1'b1;
    end else if (config_saved_i || (det_run && det_done)) begin
      modified_reg <= 1'b0;
    end
  end

  // Restored factory state is only reported at the next evaluation
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reinit_reg <= 1'b0;
    end else if (reinit_cmd) begin
      reinit_reg <= 1'b1;
    end else if (det_run && det_done) begin
      reinit_reg <= 1'b0;
    end
  end

  assign factory_next = factory_config_i || reinit_reg || modified_reg;

  // ----------------------------------------
  // Startup flags
  // ----------------------------------------
  // Sampled once per evaluation, so later changes stay invisible
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || reset_cmd) begin
      clock_missing_flag <= 1'b0;
      factory_settings_flag <= 1'b0;
    end else if (det_run && det_done) begin
      clock_missing_flag <= det_missing;
      factory_settings_flag <= factory_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      clock_missing_o <= 1'b0;
      factory_settings_o <= 1'b0;
    end else begin
      clock_missing_o <= (det_run && det_done) ? det_missing :
                         (clock_missing_flag && !reset_cmd);
      factory_settings_o <= (det_run && det_done) ? factory_next :
                            (factory_settings_flag && !reset_cmd);
    end
  end

  // ----------------------------------------
  // Axis enable gating
  // ----------------------------------------
  // Also held off while evaluating: clock state is not yet known
  assign axis_refused = axis_enable_req_i && (clock_missing_flag || evaluating);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || reset_cmd || evaluating || clock_missing_flag) begin
      axis_enable_o <= 1'b0;
    end else if (axis_disable_req_i) begin
      axis_enable_o <= 1'b0;
    end else if (axis_enable_req_i) begin
      axis_enable_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_event[IRQ_CLK_MISSING_BIT] = det_run && det_done && det_missing;
  assign irq_event[IRQ_FACTORY_BIT] = det_run && det_done && factory_next;
  assign irq_event[IRQ_REFUSED_BIT] = axis_refused;
  // New events win over a clear of the same bit
  assign irq_status_next = (irq_status_reg &
                            ~(irq_clear_wr ? pwdata_i[IRQ_W-1:0] : IRQ_RESET)) | irq_event;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_enable_reg <= IRQ_RESET;
    end else if (wr_done && (paddr_i == IRQ_ENABLE_ADDR)) begin
      irq_enable_reg <= pwdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  always_comb begin
    read_value = RDATA_RESET;
    unique case (paddr_i)
      STATUS_ADDR: begin
        read_value[CLK_MISSING_BIT] = clock_missing_flag;
        read_value[FACTORY_BIT] = factory_settings_flag;
        read_value[EVALUATING_BIT] = evaluating;
        read_value[AXIS_ENABLED_BIT] = axis_enable_o;
      end
      IRQ_STATUS_ADDR: begin
        read_value[IRQ_W-1:0] = irq_status_reg;
      end
      IRQ_ENABLE_ADDR: begin
        read_value[IRQ_W-1:0] = irq_enable_reg;
      end
      default: begin
        read_value = RDATA_RESET;
      end
    endcase
  end

  // Status writes are dropped; reads have no side effect
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= RDATA_RESET;
    end else begin
      pready_o <= access;
      pslverr_o <= access && !addr_ok;
      if (access && !pwrite_i) begin
        prdata_o <= read_value;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MISSING_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    det_run && det_done && det_missing && !reset_cmd |=> clock_missing_flag)
    else $error("Clock missing flag not raised after failed window");

  AST_MISSING_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    det_run && det_done && !det_missing && !reset_cmd |=> !clock_missing_flag ##1
    !clock_missing_o)
    else $error("Clock missing flag raised with clocks present");

  AST_ONLY_AT_EVAL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !(det_run && det_done) && !reset_cmd |=> $stable(clock_missing_flag) &&
    $stable(factory_settings_flag))
    else $error("Flag changed outside an evaluation");

  AST_RESET_CMD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    reset_cmd |=> !clock_missing_flag && !factory_settings_flag &&
    state_reg == ST_RESTART ##1 det_run)
    else $error("Reset command did not restart evaluation");

  AST_AXIS_REFUSED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clock_missing_flag && axis_enable_req_i |=> !axis_enable_o && irq_status_reg[IRQ_REFUSED_BIT])
    else $error("Axis enabled while a timing clock is missing");

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reinit_watch <= 1'b0;
    end else if (reinit_cmd) begin
      reinit_watch <= 1'b1;
    end else if (det_run && det_done) begin
      reinit_watch <= 1'b0;
    end
  end

  AST_FACTORY_REINIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    reinit_watch && det_run && det_done && !reset_cmd |=> factory_settings_flag)
    else $error("Factory flag missing after re-initialization");

  AST_FACTORY_MODIFIED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    det_run && det_done && modified_reg && !reset_cmd |=> factory_settings_flag)
    else $error("Factory flag missing after unsaved change");

  AST_FACTORY_RUNS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    factory_settings_flag && !clock_missing_flag && !evaluating && axis_enable_req_i &&
    !axis_disable_req_i && !reset_cmd |=> axis_enable_o)
    else $error("Factory flag blocked normal operation");

  AST_STATUS_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    access && !pwrite_i && paddr_i == STATUS_ADDR |=>
    prdata_o[CLK_MISSING_BIT] == $past(clock_missing_flag) &&
    prdata_o[FACTORY_BIT] == $past(factory_settings_flag) && pready_o)
    else $error("Status word does not carry the flags");

  AST_WRITE_IGNORED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_done && paddr_i == STATUS_ADDR && !(det_run && det_done) |=>
    $stable(clock_missing_flag) && $stable(factory_settings_flag))
    else $error("Status write changed a flag");

endmodule : startup_status_flags

`default_nettype wire

// >>> logic/startup_status_pkg.sv
// Purpose: Shared constants for the startup status flag bank
// Assumes: 25 MHz reference clock, APB with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none

package startup_status_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] COMMAND_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FACTORY_BIT = 7;
  localparam int CLK_MISSING_BIT = 8;
  localparam int EVALUATING_BIT = 16;
  localparam int AXIS_ENABLED_BIT = 17;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_REINIT_BIT = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_CLK_MISSING_BIT = 0;
  localparam int IRQ_FACTORY_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int EVAL_TIME_NS = 100000;
  localparam int EVAL_CYCLES = (EVAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EVAL_CNT_W = $clog2(EVAL_CYCLES + 1);

  // ----------------------------------------
  // Evaluation sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RESTART = 2'b00,
    ST_EVAL = 2'b01,
    ST_RUN = 2'b10
  } state_type;

endpackage : startup_status_pkg

`default_nettype wire

// >>> logic/clock_presence_detector.sv
// Purpose: Watch the phase and servo timing clocks for a fixed window
// Assumes: Clock pins are asynchronous to ref_clk_i
// Notes:   Window restarts whenever run_i drops
`default_nettype none

module clock_presence_detector #(
  parameter int WINDOW = startup_status_pkg::EVAL_CYCLES,
  parameter int CNT_W = startup_status_pkg::EVAL_CNT_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic run_i,
  // Timing clock pins
  input wire logic phase_clk_i,
  input wire logic servo_clk_i,
  // Result
  output logic done_o,
  output logic missing_o
);
  import startup_status_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(WINDOW - 1);

  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [1:0] seen_reg;
  logic [CNT_W-1:0] count_reg;
  logic [1:0] edge_seen;

  // ----------------------------------------
  // Two-stage synchronisers, edge detect on second stage only
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      // Reset high, so a pin stuck high shows no false edge
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      sync1_reg <= {servo_clk_i, phase_clk_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign edge_seen = seen_reg | (sync2_reg & ~prev_reg);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !run_i) begin
      count_reg <= '0;
      seen_reg <= 2'h0;
    end else begin
      if (count_reg != LAST) begin
        count_reg <= count_reg + CNT_W'(1);
      end
      seen_reg <= edge_seen;
    end
  end

  // Either clock absent is a fault
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      missing_o <= 1'b0;
    end else begin
      done_o <= run_i && (count_reg == LAST) && !done_o;
      if (run_i && (count_reg == LAST) && !done_o) begin
        missing_o <= ~&edge_seen;
      end
    end
  end

  AST_WINDOW_DONE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    done_o |-> $past(run_i) && $past(count_reg) == LAST)
    else $error("Detector finished outside its window");

endmodule : clock_presence_detector

`default_nettype wire

// >>> verif/tb_startup_status_flags.sv
// Purpose: Self-checking bench for the startup status flag bank
// Assumes: Short evaluation window, timing clocks of four reference cycles
// Notes:   APB master waits on pready_o, a cycle ceiling cuts any hang
`default_nettype none

module tb_startup_status_flags;
  import startup_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int WIN = 20;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = 8'h00;
  logic [DATA_W-1:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, axis_enable_o, clock_missing_o, factory_settings_o, irq_o;
  logic phase_clk_i = 1'b0, servo_clk_i = 1'b0;
  logic factory_config_i = 1'b0, config_modified_i = 1'b0, config_saved_i = 1'b0;
  logic axis_enable_req_i = 1'b0, axis_disable_req_i = 1'b0;
  logic phase_on = 1'b1, servo_on = 1'b1;
  logic [1:0] tick = 2'h0;
  logic [31:0] d;
  logic e;
  int error_cnt = 0, n_compared = 0, cyc = 0, k;
  int seed = 32'hC1C0;

  always #20 ref_clk_i = ~ref_clk_i;

  startup_status_flags #(.EVAL_WINDOW(WIN)) dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .phase_clk_i(phase_clk_i), .servo_clk_i(servo_clk_i),
    .factory_config_i(factory_config_i), .config_modified_i(config_modified_i),
    .config_saved_i(config_saved_i), .axis_enable_req_i(axis_enable_req_i),
    .axis_disable_req_i(axis_disable_req_i), .axis_enable_o(axis_enable_o),
    .clock_missing_o(clock_missing_o), .factory_settings_o(factory_settings_o), .irq_o(irq_o)
  );

  // ----------------------------------------
  // Timing clocks, stopped ones hold level
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    tick <= tick + 2'h1;
    if (tick[0]) begin
      if (phase_on) phase_clk_i <= ~phase_clk_i;
      if (servo_on) servo_clk_i <= ~servo_clk_i;
    end
  end

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task final_report;
    $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Request held until pready_o is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp, what);
  endtask : rdchk

  task wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, e);
  endtask : wr

  // Polls the evaluating bit; bounded so a stuck sequencer cannot hang
  task wait_eval;
    int n;
    repeat (3) @(posedge ref_clk_i);
    n = 0;
    do begin
      apb(1'b0, STATUS_ADDR, 32'h0, d, e);
      n++;
    end while (d[EVALUATING_BIT] !== 1'b0 && n < 40);
    check(d[EVALUATING_BIT], 1'b0, "evaluation done");
    repeat (2) @(posedge ref_clk_i);
  endtask : wait_eval

  task reeval;
    wr(COMMAND_ADDR, 32'h1);
    wait_eval();
  endtask : reeval

  task axis(input logic en, input logic dis);
    @(posedge ref_clk_i);
    axis_enable_req_i <= en;
    axis_disable_req_i <= dis;
    @(posedge ref_clk_i);
    axis_enable_req_i <= 1'b0;
    axis_disable_req_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : axis

  task pulse_cfg(input logic m, input logic s);
    @(posedge ref_clk_i);
    config_modified_i <= m;
    config_saved_i <= s;
    @(posedge ref_clk_i);
    config_modified_i <= 1'b0;
    config_saved_i <= 1'b0;
  endtask : pulse_cfg

  function automatic logic [31:0] stat_exp(input logic cm, input logic fs, input logic ax);
    logic [31:0] r;
    r = 32'h0;
    r[CLK_MISSING_BIT] = cm;
    r[FACTORY_BIT] = fs;
    r[AXIS_ENABLED_BIT] = ax;
    return r;
  endfunction : stat_exp

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    check({clock_missing_o, factory_settings_o, irq_o}, 3'h0, "reset outputs");
    wait_eval();
    rdchk(STATUS_ADDR, stat_exp(1'b0, 1'b0, 1'b0), "status clean");
    axis(1'b1, 1'b0);
    check(axis_enable_o, 1'b1, "axis enabled");
    rdchk(STATUS_ADDR, stat_exp(1'b0, 1'b0, 1'b1), "status axis");
    axis(1'b1, 1'b1);
    check(axis_enable_o, 1'b0, "disable wins");
    wr(IRQ_ENABLE_ADDR, 32'h7);
    rdchk(IRQ_ENABLE_ADDR, 32'h7, "irq enable");
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 8'h14 + 8'(4 * ($unsigned($random(seed)) % 59)), 32'h0, d, e);
      check(d, 32'h0, "unmapped data");
      check(e, 1'b1, "unmapped error");
    end
    // Clock loss after start must not show until re-evaluation
    servo_on <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    check(clock_missing_o, 1'b0, "no live update");
    for (k = 0; k < 3; k++) begin
      phase_on <= (k != 1);
      servo_on <= (k != 2);
      reeval();
      check(clock_missing_o, k != 0, "missing flag");
      rdchk(STATUS_ADDR, stat_exp(k != 0, 1'b0, 1'b0), "status missing");
    end
    check(irq_o, 1'b1, "irq raised");
    axis(1'b1, 1'b0);
    check(axis_enable_o, 1'b0, "axis refused");
    rdchk(IRQ_STATUS_ADDR, 32'h5, "irq status");
    wr(IRQ_CLEAR_ADDR, 32'h7);
    rdchk(IRQ_STATUS_ADDR, 32'h0, "irq cleared");
    check(irq_o, 1'b0, "irq dropped");
    // Clocks back: flag holds, status writes are ignored
    servo_on <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    for (k = 0; k < 3; k++) wr(STATUS_ADDR, $random(seed));
    rdchk(STATUS_ADDR, stat_exp(1'b1, 1'b0, 1'b0), "flag held");
    check(clock_missing_o, 1'b1, "held after clock return");
    reeval();
    check(clock_missing_o, 1'b0, "cleared by reset command");
    factory_config_i <= 1'b1;
    reeval();
    check(factory_settings_o, 1'b1, "factory config");
    rdchk(IRQ_STATUS_ADDR, 32'h2, "factory irq");
    factory_config_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    check(factory_settings_o, 1'b1, "factory held");
    reeval();
    check(factory_settings_o, 1'b0, "factory gone");
    pulse_cfg(1'b1, 1'b0);
    reeval();
    check(factory_settings_o, 1'b1, "modified since save");
    axis(1'b1, 1'b0);
    check(axis_enable_o, 1'b1, "runs while modified");
    pulse_cfg(1'b1, 1'b0);
    pulse_cfg(1'b0, 1'b1);
    reeval();
    check(factory_settings_o, 1'b0, "saved after modify");
    wr(COMMAND_ADDR, 32'h2);
    repeat (5) @(posedge ref_clk_i);
    check(factory_settings_o, 1'b0, "reinit waits");
    reeval();
    check(factory_settings_o, 1'b1, "reinit reported");
    final_report();
  end

endmodule : tb_startup_status_flags

`default_nettype wire
